/* core/ctl_core.sv */
// Purpose: alarm, output power, manual, ramp and dwell supervision of a temperature controller
// Assumes: inputs synchronous to aclk; the loop algorithm supplies pid_heat_pct
// Notes: registers over AXI4-Lite; temperatures in hundredths of a degree
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ctl_params.svh"

// What this block does
// - each alarm channel has its own special-function selector
// - latching alarm sets output and indicator at first alarm condition
// - latched alarm stays on until reset
// - hold function suppresses alarms until process first reaches setpoint
// - latch-and-hold suppresses until setpoint reached, then latches
// - reported output power stays within 0 to 100
// - on-off control reports only 0 or 100 percent outside manual, where the manual power is reported
// - proportional power sets ON share of each cycle period
// - second-channel power valid only when alarm 2 is cooling
// - scroll held 3.2 s and released in output view enters manual, flashing
// - manual drives output open loop, up raises, down lowers power
// - zero proportional band refuses manual and shows an error code
// - ramp rate accepted from 0 to 55.55 degrees per minute
// - zero ramp rate makes working setpoint jump to target
// - nonzero ramp moves working setpoint toward target at set rate
// - timer-on mode: alarm 1 open at power-up, closes after dwell
// - timer-off mode: alarm 1 closed at power-up, opens after dwell
// - dwell timer starts only when process first reaches setpoint
// - cooling band and dead band held and compared in hundredths of a degree
// - dwell timer is reset only by power-up
// - zero proportional band selects on-off control with hysteresis
module ctl_core
  import ctl_pkg::*;
#(
  parameter int PV_W = 24,
  parameter logic [35:0] MINUTE_CYCLES = 36'(64'(`MINUTE_TICK_S) * 64'd1000000000 / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] DECI_CYCLES = 32'(64'(`DECI_SECOND_MS) * 64'd1000000 / 64'(`CLK_PERIOD_NS)),
  parameter logic [31:0] LONG_PRESS_CYCLES = 32'(64'(`LONG_PRESS_MS) * 64'd1000000 / 64'(`CLK_PERIOD_NS))
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic signed [PV_W-1:0] process_value,
  input wire logic [7:0] pid_heat_pct,
  input wire logic key_scroll,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic view_output_pct,
  output logic primary_output,
  output logic first_alarm_output,
  output logic second_alarm_output,
  output logic display_flash,
  output logic error_code_show
);

  ////////////////////////////////////////////////////////////////////////////
  // register file and AXI4-Lite slave
  logic [31:0] target_setpoint, ramp_rate, proportional_band, onoff_hysteresis;
  logic [31:0] alarm1_setpoint_or_dwell_time, alarm1_hysteresis, alarm_cfg, alarm2_setpoint;
  logic [31:0] cooling_prop_band, heat_cool_dead_band, cycle_times;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic wr_hit;
  logic [31:0] status_word, pct_word, rd_data;
  logic rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr <= `OFS_CYCLE_TIME) && (aw_addr[1:0] == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      target_setpoint <= 32'h00000000;
      ramp_rate <= 32'h00000000;
      proportional_band <= `RST_PROP_BAND;
      onoff_hysteresis <= 32'h00000000;
      alarm1_setpoint_or_dwell_time <= 32'h00000000;
      alarm1_hysteresis <= 32'h00000000;
      alarm_cfg <= 32'h00000000;
      alarm2_setpoint <= 32'h00000000;
      cooling_prop_band <= 32'h00000000;
      heat_cool_dead_band <= 32'h00000000;
      cycle_times <= `RST_CYCLE_TIME;
    end
    else if (do_write && wr_hit)
    begin
      unique case (aw_addr)
        `OFS_TARGET_SP: target_setpoint <= merge(target_setpoint, w_data, w_strb);
        `OFS_RAMP_RATE:
        begin
          // out-of-range rates saturate rather than wrap to a slow ramp
          ramp_rate <= (merge(ramp_rate, w_data, w_strb) > `RAMP_RATE_MAX) ? `RAMP_RATE_MAX
                       : merge(ramp_rate, w_data, w_strb);
        end
        `OFS_PROP_BAND: proportional_band <= merge(proportional_band, w_data, w_strb);
        `OFS_ONOFF_HYSTERESIS: onoff_hysteresis <= merge(onoff_hysteresis, w_data, w_strb);
        `OFS_A1_SP: alarm1_setpoint_or_dwell_time <= merge(alarm1_setpoint_or_dwell_time, w_data, w_strb);
        `OFS_A1_HYSTERESIS: alarm1_hysteresis <= merge(alarm1_hysteresis, w_data, w_strb);
        `OFS_ALARM_CFG: alarm_cfg <= merge(alarm_cfg, w_data, w_strb);
        `OFS_A2_SP: alarm2_setpoint <= merge(alarm2_setpoint, w_data, w_strb);
        `OFS_COOL_BAND: cooling_prop_band <= merge(cooling_prop_band, w_data, w_strb);
        `OFS_DEAD_BAND: heat_cool_dead_band <= merge(heat_cool_dead_band, w_data, w_strb);
        `OFS_CYCLE_TIME: cycle_times <= merge(cycle_times, w_data, w_strb);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescalers
  logic [35:0] min_cnt;
  logic [31:0] deci_cnt;
  logic minute_tick, deci_tick;
  assign minute_tick = (min_cnt == MINUTE_CYCLES - 36'h000000001);
  assign deci_tick = (deci_cnt == DECI_CYCLES - 32'h00000001);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      min_cnt <= 36'h000000000;
      deci_cnt <= 32'h00000000;
    end
    else
    begin
      min_cnt <= minute_tick ? 36'h000000000 : min_cnt + 36'h000000001;
      deci_cnt <= deci_tick ? 32'h00000000 : deci_cnt + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramped working setpoint and first arrival at setpoint
  logic signed [PV_W-1:0] goal_sp, work_sp, step;
  logic sp_loaded, reached, direct_action, on_off;
  assign goal_sp = PV_W'(target_setpoint);
  assign step = PV_W'(ramp_rate);
  assign direct_action = alarm_cfg[`CFG_DIRECT_BIT];
  assign on_off = (proportional_band == 32'h00000000);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sp_loaded <= 1'b0;
      work_sp <= '0;
      reached <= 1'b0;
    end
    else
    begin
      // the ramp starts from the target tracked while the rate was zero, not from the measured value
      sp_loaded <= 1'b1;
      if (ramp_rate == 32'h00000000)
        work_sp <= goal_sp;
      else if (!sp_loaded)
        work_sp <= process_value;
      else if (minute_tick)
        work_sp <= (work_sp < goal_sp) ? ((goal_sp - work_sp > step) ? work_sp + step : goal_sp)
                   : ((work_sp - goal_sp > step) ? work_sp - step : goal_sp);
      if (direct_action ? (process_value <= goal_sp) : (process_value >= goal_sp))
        reached <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dwell timer, cleared by reset only
  logic [31:0] dwell_elapsed;
  logic dwell_done;
  assign dwell_done = reached && (dwell_elapsed >= alarm1_setpoint_or_dwell_time);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dwell_elapsed <= 32'h00000000;
    else if (reached && minute_tick && !dwell_done)
      dwell_elapsed <= dwell_elapsed + 32'h00000001;
  end

  ////////////////////////////////////////////////////////////////////////////
  // keypad: long scroll enters or leaves manual; up and down trim power
  logic [31:0] press_cnt;
  logic scroll_d, up_d, down_d, long_release;
  logic manual, refused;
  logic [7:0] manual_pct, heat_pct, cool_pct;
  assign long_release = scroll_d && !key_scroll && (press_cnt >= LONG_PRESS_CYCLES);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      press_cnt <= 32'h00000000;
      scroll_d <= 1'b0;
      up_d <= 1'b0;
      down_d <= 1'b0;
      manual <= 1'b0;
      refused <= 1'b0;
      manual_pct <= 8'h00;
    end
    else
    begin
      scroll_d <= key_scroll;
      up_d <= key_up;
      down_d <= key_down;
      press_cnt <= !key_scroll ? 32'h00000000 : (press_cnt == 32'hFFFFFFFF) ? press_cnt : press_cnt + 32'h00000001;
      // the error code stays until the operator presses up or down; a refusal in the same cycle wins
      if ((key_up && !up_d) || (key_down && !down_d))
        refused <= 1'b0;
      if (long_release && manual)
        manual <= 1'b0;
      else if (long_release && view_output_pct && on_off)
        refused <= 1'b1;
      else if (long_release && view_output_pct)
      begin
        manual <= 1'b1;
        manual_pct <= heat_pct;
      end
      else if (manual && key_up && !up_d && manual_pct < `PCT_FULL)
        manual_pct <= manual_pct + 8'h01;
      else if (manual && key_down && !down_d && manual_pct != 8'h00)
        manual_pct <= manual_pct - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output power for heating and cooling channels
  logic signed [PV_W-1:0] cool_err, onoff_margin;
  logic onoff_on, heat_on_now;
  logic [31:0] cool_ratio;
  logic [7:0] next_heat_pct, next_cool_pct;
  assign onoff_margin = PV_W'(onoff_hysteresis);
  assign cool_err = process_value - work_sp - PV_W'(heat_cool_dead_band);
  assign cool_ratio = (cooling_prop_band == 32'h00000000) ? 32'h00000000
                      : 32'(32'(cool_err) * 32'sh64) / cooling_prop_band;
  assign heat_on_now = direct_action ? (process_value > work_sp + onoff_margin)
                       : (process_value < work_sp - onoff_margin);
  assign next_heat_pct = manual ? manual_pct : on_off ? (onoff_on ? `PCT_FULL : 8'h00)
                         : (pid_heat_pct > `PCT_FULL) ? `PCT_FULL : pid_heat_pct;
  assign next_cool_pct = (cool_err <= 0) ? 8'h00
                         : (cooling_prop_band == 32'h00000000 || cool_ratio >= 32'(`PCT_FULL)) ? `PCT_FULL
                         : cool_ratio[7:0];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      onoff_on <= 1'b0;
      heat_pct <= 8'h00;
      cool_pct <= 8'h00;
    end
    else
    begin
      // off once the setpoint is crossed, on again past the hysteresis
      if (heat_on_now)
        onoff_on <= 1'b1;
      else if (direct_action ? (process_value <= work_sp) : (process_value >= work_sp))
        onoff_on <= 1'b0;
      heat_pct <= next_heat_pct;
      cool_pct <= next_cool_pct;
    end
  end

  duty_if heat_ch ();
  duty_if cool_ch ();
  assign heat_ch.tick = deci_tick;
  assign heat_ch.period = cycle_times[15:0];
  assign heat_ch.pct = heat_pct;
  assign cool_ch.tick = deci_tick;
  assign cool_ch.period = cycle_times[31:16];
  assign cool_ch.pct = cool_pct;
  duty_gen heat_gen (.aclk(aclk), .aresetn(aresetn), .ch(heat_ch));
  duty_gen cool_gen (.aclk(aclk), .aresetn(aresetn), .ch(cool_ch));

  ////////////////////////////////////////////////////////////////////////////
  // two alarm channels, each with its own special function
  sf_t sf [2];
  logic [1:0] a_out, latched, raw_on;
  assign sf[0] = sf_t'(alarm_cfg[`CFG_A1_SF_LSB +: 3]);
  assign sf[1] = sf_t'(alarm_cfg[`CFG_A2_SF_LSB +: 3]);
  generate
    for (genvar g = 0; g < 2; g++)
    begin : chan
      alarm_mode_t mode;
      logic signed [PV_W-1:0] thr, ahy;
      logic high, trip, clear, armed, latching, cond;
      assign mode = alarm_mode_t'(alarm_cfg[(g == 0 ? `CFG_A1_MODE_LSB : `CFG_A2_MODE_LSB) +: 2]);
      assign ahy = (g == 0) ? PV_W'(alarm1_hysteresis) : '0;
      assign thr = PV_W'(g == 0 ? alarm1_setpoint_or_dwell_time : alarm2_setpoint)
                   + ((mode == AM_DEV_HIGH || mode == AM_DEV_LOW) ? goal_sp : '0);
      assign high = (mode == AM_DEV_HIGH || mode == AM_FULL_HIGH);
      assign trip = high ? (process_value > thr) : (process_value < thr);
      assign clear = high ? (process_value < thr - ahy) : (process_value > thr + ahy);
      assign armed = !(sf[g] == SF_HOLD || sf[g] == SF_LATCH_HOLD) || reached;
      assign latching = (sf[g] == SF_LATCH || sf[g] == SF_LATCH_HOLD);
      assign cond = armed && (raw_on[g] || trip);
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          raw_on[g] <= 1'b0;
          latched[g] <= 1'b0;
          a_out[g] <= 1'b0;
        end
        else
        begin
          raw_on[g] <= armed && (trip || (raw_on[g] && !clear));
          if (latching && cond)
            latched[g] <= 1'b1;
          unique case (sf[g])
            SF_TIMER_ON: a_out[g] <= (g == 0) && dwell_done;
            SF_TIMER_OFF: a_out[g] <= (g == 0) && !dwell_done;
            SF_COOL: a_out[g] <= cool_ch.out;
            default: a_out[g] <= cond || (latching && latched[g]);
          endcase
        end
      end
    end
  endgenerate

  assign primary_output = heat_ch.out;
  assign first_alarm_output = a_out[0];
  assign second_alarm_output = a_out[1];
  assign display_flash = manual;
  assign error_code_show = refused;

  ////////////////////////////////////////////////////////////////////////////
  // read side
  assign status_word = {26'h0, sf[1] == SF_COOL, reached, a_out, refused, manual};
  assign pct_word = {16'h0, cool_pct, heat_pct};
  assign rd_hit = (s_axi_araddr <= `OFS_DWELL) && (s_axi_araddr[1:0] == 2'h0);
  assign rd_data = (s_axi_araddr == `OFS_TARGET_SP) ? target_setpoint
                 : (s_axi_araddr == `OFS_RAMP_RATE) ? ramp_rate
                 : (s_axi_araddr == `OFS_PROP_BAND) ? proportional_band
                 : (s_axi_araddr == `OFS_ONOFF_HYSTERESIS) ? onoff_hysteresis
                 : (s_axi_araddr == `OFS_A1_SP) ? alarm1_setpoint_or_dwell_time
                 : (s_axi_araddr == `OFS_A1_HYSTERESIS) ? alarm1_hysteresis
                 : (s_axi_araddr == `OFS_ALARM_CFG) ? alarm_cfg
                 : (s_axi_araddr == `OFS_A2_SP) ? alarm2_setpoint
                 : (s_axi_araddr == `OFS_COOL_BAND) ? cooling_prop_band
                 : (s_axi_araddr == `OFS_DEAD_BAND) ? heat_cool_dead_band
                 : (s_axi_araddr == `OFS_CYCLE_TIME) ? cycle_times
                 : (s_axi_araddr == `OFS_STATUS) ? status_word
                 : (s_axi_araddr == `OFS_OUT_PCT) ? pct_word
                 : (s_axi_araddr == `OFS_WORK_SP) ? 32'(work_sp)
                 : (s_axi_araddr == `OFS_DWELL) ? dwell_elapsed : 32'h00000000;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_pct_range: assert property (@(posedge aclk) disable iff (!aresetn) heat_pct <= `PCT_FULL && cool_pct <= `PCT_FULL)
    else $error("power percentage above full scale");
  chk_onoff_levels: assert property (@(posedge aclk) disable iff (!aresetn)
    on_off && !manual |=> heat_pct == 8'h00 || heat_pct == `PCT_FULL)
    else $error("on-off power not 0 or 100");
  chk_latch_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    sf[0] == SF_LATCH && a_out[0] && $stable(alarm_cfg) |=> a_out[0])
    else $error("latched alarm released");
  chk_hold_suppress: assert property (@(posedge aclk) disable iff (!aresetn)
    sf[0] == SF_HOLD && !reached && $stable(alarm_cfg) |=> !a_out[0])
    else $error("held alarm raised before setpoint reached");
  chk_manual_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    long_release && view_output_pct && on_off && !manual |=> !manual && error_code_show)
    else $error("manual entered under on-off control");
  chk_manual_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    long_release && view_output_pct && !on_off && !manual |=> display_flash)
    else $error("manual not entered after long scroll");
  chk_ramp_off: assert property (@(posedge aclk) disable iff (!aresetn)
    ramp_rate == 32'h00000000 ##1 ramp_rate == 32'h00000000 |-> work_sp == $past(goal_sp))
    else $error("working setpoint not following target with ramp off");
  chk_reached_sticky: assert property (@(posedge aclk) disable iff (!aresetn) reached |=> reached)
    else $error("setpoint arrival flag cleared");
  chk_timer_off_contact: assert property (@(posedge aclk) disable iff (!aresetn)
    sf[0] == SF_TIMER_OFF && !dwell_done && $stable(alarm_cfg) |=> first_alarm_output)
    else $error("timer-off contact opened early");
  chk_ramp_limit: assert property (@(posedge aclk) disable iff (!aresetn) ramp_rate <= `RAMP_RATE_MAX)
    else $error("ramp rate above limit");
  cov_manual: cover property (@(posedge aclk) disable iff (!aresetn) !manual ##1 manual);
  cov_dwell: cover property (@(posedge aclk) disable iff (!aresetn) !dwell_done ##1 dwell_done);
  cov_latch: cover property (@(posedge aclk) disable iff (!aresetn) !latched[0] ##1 latched[0]);
endmodule

/* core/ctl_params.svh */
// Purpose: offsets, field positions, reset values and timing counts of the controller supervisor
// Assumes: 100 MHz aclk; temperatures in hundredths of a degree
// Notes: byte addresses on the AXI4-Lite register window
`ifndef CTL_PARAMS_SVH
`define CTL_PARAMS_SVH

`define CLK_PERIOD_NS 10
`define MINUTE_TICK_S 60
`define DECI_SECOND_MS 100
`define LONG_PRESS_MS 3200

`define OFS_TARGET_SP 8'h00
`define OFS_RAMP_RATE 8'h04
`define OFS_PROP_BAND 8'h08
`define OFS_ONOFF_HYSTERESIS 8'h0C
`define OFS_A1_SP 8'h10
`define OFS_A1_HYSTERESIS 8'h14
`define OFS_ALARM_CFG 8'h18
`define OFS_A2_SP 8'h1C
`define OFS_COOL_BAND 8'h20
`define OFS_DEAD_BAND 8'h24
`define OFS_CYCLE_TIME 8'h28
`define OFS_STATUS 8'h30
`define OFS_OUT_PCT 8'h34
`define OFS_WORK_SP 8'h38
`define OFS_DWELL 8'h3C

`define CFG_A1_SF_LSB 0
`define CFG_A2_SF_LSB 3
`define CFG_A1_MODE_LSB 6
`define CFG_A2_MODE_LSB 8
`define CFG_DIRECT_BIT 10

`define RAMP_RATE_MAX 32'h000015B3
`define PCT_FULL 8'h64
`define RST_CYCLE_TIME 32'h00C800C8
`define RST_PROP_BAND 32'h000003E8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* core/ctl_pkg.sv */
// Purpose: shared types of the controller supervisor
// Assumes: nothing beyond the params header
// Notes: special function codes follow the order of the enum
package ctl_pkg;
  typedef enum logic [2:0] {SF_NONE, SF_LATCH, SF_HOLD, SF_LATCH_HOLD, SF_TIMER_ON, SF_TIMER_OFF, SF_COOL} sf_t;
  typedef enum logic [1:0] {AM_DEV_HIGH, AM_DEV_LOW, AM_FULL_HIGH, AM_FULL_LOW} alarm_mode_t;
endpackage

/* core/duty_if.sv */
// Purpose: carries one duty channel between the supervisor and its duty generator
// Assumes: tick is a one-cycle pulse every tenth of a second
// Notes: period counts tenths of a second
`timescale 1ns/1ps
interface duty_if;
  logic tick;
  logic [15:0] period;
  logic [7:0] pct;
  logic out;
  modport gen (input tick, input period, input pct, output out);
  modport drv (output tick, output period, output pct, input out);
endinterface

/* core/duty_gen.sv */
// Purpose: time-proportioned on/off drive for one output
// Assumes: pct is already limited to 0..100
// Notes: a zero period holds the output off
`timescale 1ns/1ps
module duty_gen
  import ctl_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  duty_if.gen ch
);
  logic [15:0] pos;
  logic [23:0] on_lhs;
  logic [23:0] on_rhs;
  logic wrap;

  assign wrap = (pos + 16'h0001 >= ch.period);
  assign on_lhs = 24'(pos) * 24'h000064;
  assign on_rhs = 24'(ch.pct) * 24'(ch.period);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pos <= 16'h0000;
      ch.out <= 1'b0;
    end
    else
    begin
      if (ch.tick)
        pos <= wrap ? 16'h0000 : pos + 16'h0001;
      ch.out <= (on_lhs < on_rhs);
    end
  end
endmodule

/* verif/plant_model.sv */
// Purpose: process seen by the sensor, heated by the relay
// Assumes: one hundredth of a degree per cycle
// Notes: load places the process at once, so alarm cases need no long wait
`timescale 1ns/1ps
module plant_model
(
  input wire logic aclk,
  input wire logic heat,
  input wire logic load,
  input wire logic signed [23:0] start,
  output logic signed [23:0] pv = 24'sh000000
);
  always @(posedge aclk)
    pv <= load ? start : heat ? pv + 24'sh000001 : pv - 24'sh000001;
endmodule

/* verif/tb_top.sv */
// Purpose: self-checking bench of the controller supervisor
// Assumes: shortened minute, tenth and long-press counts
// Notes: expected values come from the bench's own model
`timescale 1ns/1ps
`include "ctl_params.svh"
module tb_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ks = 0, ku = 0, kd = 0, vw = 0, ld = 1;
  logic awr, wr, bv, arr, rv, po, a1, a2, fl, er;
  logic [7:0] awa = 8'h00, ara = 8'h00, pid = 8'h00;
  logic [31:0] wd = 32'h00000000, rd, rdat, seed = 32'h0000003B, mpct;
  logic [1:0] br, rr, resp;
  // start below the reset target so arrival at setpoint is a later event
  logic signed [23:0] pv, pv0 = 24'shFFF000;
  int err_total = 0, checked = 0, ticks = 0, ons = 0;
  always #5 aclk = ~aclk;
  plant_model i_plant (.aclk(aclk), .heat(po), .load(ld), .start(pv0), .pv(pv));
  ctl_core #(.MINUTE_CYCLES(36'h14), .DECI_CYCLES(32'h4), .LONG_PRESS_CYCLES(32'h8)) i_dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .process_value(pv), .pid_heat_pct(pid),
    .key_scroll(ks), .key_up(ku), .key_down(kd), .view_output_pct(vw), .primary_output(po),
    .first_alarm_output(a1), .second_alarm_output(a2), .display_flash(fl), .error_code_show(er));
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic results();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    checked++;
    if (got !== want)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, want);
    end
  endtask
  // every task ends at least one edge after its last release, so no strobe is set twice in a time step
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rdat = rd;
    resp = rr;
    rry <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic put(input logic [23:0] v, input int k, input int n);
    pv0 <= v;
    ld <= (k == 0);
    ks <= (k == 1);
    ku <= (k == 2);
    kd <= (k == 3);
    repeat (n) @(posedge aclk);
    {ld, ks, ku, kd} <= 4'h0;
    repeat (3) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge aclk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    ld <= 1'b0;
    @(posedge aclk);
    axr(`OFS_PROP_BAND);
    cmp(rdat, `RST_PROP_BAND);
    axr(8'h40);
    cmp({rdat[29:0], resp}, {30'h0, `RESP_SLVERR});
    axw(`OFS_RAMP_RATE, 32'h0000FFFF);
    cmp(32'(resp), 32'(`RESP_OKAY));
    axw(8'h2C, 32'h00000001);
    cmp(32'(resp), 32'(`RESP_SLVERR));
    axr(`OFS_RAMP_RATE);
    cmp(rdat, `RAMP_RATE_MAX);
    axw(`OFS_RAMP_RATE, 32'h00000000);
    axw(`OFS_TARGET_SP, 32'h00001234);
    axr(`OFS_WORK_SP);
    cmp(rdat, 32'h00001234);
    for (int i = 0; i < 4; i++)
    begin
      seed = xs(seed);
      pid <= seed[7:0];
      repeat (3) @(posedge aclk);
      axr(`OFS_OUT_PCT);
      cmp(rdat & 32'hFF, (seed[7:0] > `PCT_FULL) ? 32'h64 : 32'(seed[7:0]));
    end
    axw(`OFS_A1_SP, 32'h00000100);
    axw(`OFS_A2_SP, 32'h00000100);
    axw(`OFS_ALARM_CFG, 32'h00000291);
    put(24'h000500, 0, 1);
    cmp(32'({a1, a2}), 32'h2);
    put(24'h000000, 0, 1);
    cmp(32'({a1, a2}), 32'h2);
    put(24'h002000, 0, 1);
    cmp(32'({a1, a2}), 32'h3);
    axr(`OFS_STATUS);
    cmp(rdat & 32'h3C, 32'h1C);
    axr(`OFS_DWELL);
    axw(`OFS_A1_SP, rdat + 32'h3);
    axw(`OFS_ALARM_CFG, 32'h00000004);
    cmp(32'(a1), 32'h0);
    repeat (120) @(posedge aclk);
    cmp(32'(a1), 32'h1);
    axw(`OFS_ALARM_CFG, 32'h00000005);
    cmp(32'(a1), 32'h0);
    pid <= 8'h32;
    vw <= 1'b1;
    axw(`OFS_PROP_BAND, 32'h00000000);
    put(24'h000000, 1, 10);
    cmp(32'({fl, er}), 32'h1);
    axw(`OFS_PROP_BAND, `RST_PROP_BAND);
    put(24'h000000, 3, 1);
    put(24'h000000, 1, 10);
    cmp(32'({fl, er}), 32'h2);
    mpct = 32'h32;
    pid <= 8'h00;
    for (int i = 2; i < 5; i++)
    begin
      put(24'h000000, (i == 2) ? 2 : 3, 1);
      mpct = (i == 2) ? mpct + 1 : mpct - 1;
      axr(`OFS_OUT_PCT);
      cmp(rdat & 32'hFF, mpct);
    end
    repeat (800) @(posedge aclk) ons += int'(po);
    cmp(32'(ons), mpct * 32'd200 / 32'd100 * 32'd4);
    results();
  end
endmodule
